// [logic/rx_bit_fifo.v]
`timescale 1ns/100ps
module rx_bit_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire core_clk,
   input wire resetn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;
   integer i;

   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_reg[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// [logic/rx_clock_defs.vh]
// Function
// - default transceiver master clock is the internal master clock divided by one hundred
// - source select 1 takes the external master clock pin; 0 ignores that pin
// - recovered clock pin carries the recovered clock while its enable is set
// - recovered clock forwards to the input clock slot named by the destination field
// - disabled recovered clock pin outputs the level of the recovered clock invert bit
// - multipurpose pin, when enabled, carries frame sync or multiframe sync per select
// - disabled multipurpose pin outputs the level of the multipurpose invert bit
// - mode pattern 0x makes serial output carry received DS1/E1 bits as NRZ
// - serial output updates on the recovered clock edge chosen by the invert bit
// - serial output is held low while its serial data enable is clear
// - in modes other than DS1/E1 the serial output is held low
// - power-down set puts the differential line inputs in high impedance
`ifndef RX_CLOCK_DEFS_VH
`define RX_CLOCK_DEFS_VH
`define RXC_MCLK_DIV 100
`define RXC_MCLK_CNT_W 7
`define RXC_SLOT_COUNT 14
`define RXC_SLOT_SEL_W 4
`define RXC_MODE_W 2
`define RXC_MODE_NON_DS1E1_BIT 1
`define RXC_MPO_SRC_MULTIFRAME 1'b1
`define RXC_FIFO_DEPTH 4
`define RXC_FIFO_AW 2
`define RXC_FIFO_WIDTH 1
`endif

// [logic/timing_rx_clock_output_mux.v]
`timescale 1ns/100ps
`include "rx_clock_defs.vh"
module timing_rx_clock_output_mux (
   input wire core_clk,
   input wire resetn,
   input wire master_clock_tick,
   input wire ext_master_clock_pin_a,
   input wire ext_master_clock_pin_b,
   input wire master_clock_source_sel_a,
   input wire master_clock_source_sel_b,
   output wire xcvr_master_clock_tick_a,
   output wire xcvr_master_clock_tick_b,
   input wire rx_recovered_clock_a,
   input wire rx_recovered_clock_b,
   input wire rx_bit_data_a,
   input wire rx_bit_data_b,
   input wire rx_bit_valid_a,
   input wire rx_bit_valid_b,
   output wire rx_bit_ready_a,
   output wire rx_bit_ready_b,
   input wire rx_frame_sync_a,
   input wire rx_frame_sync_b,
   input wire rx_multiframe_sync_a,
   input wire rx_multiframe_sync_b,
   input wire [1:0] rx_line_mode_a,
   input wire [1:0] rx_line_mode_b,
   input wire recovered_clock_out_en_a,
   input wire recovered_clock_out_en_b,
   input wire recovered_clock_invert_a,
   input wire recovered_clock_invert_b,
   input wire [3:0] recovered_clock_dest_sel_a,
   input wire [3:0] recovered_clock_dest_sel_b,
   input wire rx_multipurpose_out_en_a,
   input wire rx_multipurpose_out_en_b,
   input wire rx_multipurpose_source_sel_a,
   input wire rx_multipurpose_source_sel_b,
   input wire rx_multipurpose_invert_a,
   input wire rx_multipurpose_invert_b,
   input wire rx_serial_data_en_a,
   input wire rx_serial_data_en_b,
   input wire rx_power_down_a,
   input wire rx_power_down_b,
   output wire recovered_clock_out_a,
   output wire recovered_clock_out_b,
   output wire [13:0] recovered_clock_slot_a,
   output wire [13:0] recovered_clock_slot_b,
   output wire rx_multipurpose_out_a,
   output wire rx_multipurpose_out_b,
   output wire rx_serial_data_out_a,
   output wire rx_serial_data_out_b,
   output wire rx_line_input_en_a,
   output wire rx_line_input_en_b
);
   // every vector below holds receiver a in its low bit or field and receiver b in its high bit or field
   wire [1:0] ext_pin = {ext_master_clock_pin_b, ext_master_clock_pin_a};
   wire [1:0] src_sel = {master_clock_source_sel_b, master_clock_source_sel_a};
   wire [1:0] rclk_in = {rx_recovered_clock_b, rx_recovered_clock_a};
   wire [1:0] bit_data = {rx_bit_data_b, rx_bit_data_a};
   wire [1:0] bit_valid = {rx_bit_valid_b, rx_bit_valid_a};
   wire [1:0] fsync = {rx_frame_sync_b, rx_frame_sync_a};
   wire [1:0] mfsync = {rx_multiframe_sync_b, rx_multiframe_sync_a};
   wire [3:0] mode = {rx_line_mode_b, rx_line_mode_a};
   wire [1:0] rc_en = {recovered_clock_out_en_b, recovered_clock_out_en_a};
   wire [1:0] rc_inv = {recovered_clock_invert_b, recovered_clock_invert_a};
   wire [7:0] dest = {recovered_clock_dest_sel_b, recovered_clock_dest_sel_a};
   wire [1:0] mp_en = {rx_multipurpose_out_en_b, rx_multipurpose_out_en_a};
   wire [1:0] mp_sel = {rx_multipurpose_source_sel_b, rx_multipurpose_source_sel_a};
   wire [1:0] mp_inv = {rx_multipurpose_invert_b, rx_multipurpose_invert_a};
   wire [1:0] sd_en = {rx_serial_data_en_b, rx_serial_data_en_a};
   wire [1:0] pd = {rx_power_down_b, rx_power_down_a};
   wire [1:0] mclk_tick;
   wire [1:0] bit_ready;
   wire [1:0] rclk_pin;
   wire [27:0] slot;
   wire [1:0] mp_pin;
   wire [1:0] sd_pin;

   reg [`RXC_MCLK_CNT_W-1:0] div_cnt_reg;
   reg div_tick_reg;

   function edge_seen;
      input prev;
      input cur;
      input falling;
      begin
         edge_seen = falling ? (prev & ~cur) : (~prev & cur);
      end
   endfunction

   function [`RXC_SLOT_COUNT-1:0] slot_decode;
      input [`RXC_SLOT_SEL_W-1:0] sel;
      input clk_level;
      integer k;
      begin
         slot_decode = {`RXC_SLOT_COUNT{1'b0}};
         // zero and codes above fourteen forward nowhere
         for (k = 0; k < `RXC_SLOT_COUNT; k = k + 1) begin
            if (sel == k + 1) begin
               slot_decode[k] = clk_level;
            end
         end
      end
   endfunction

   // shared divider: one internal master clock serves both receivers
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_reg <= {`RXC_MCLK_CNT_W{1'b0}};
         div_tick_reg <= 1'b0;
      end else begin
         div_tick_reg <= 1'b0;
         if (master_clock_tick) begin
            if (div_cnt_reg == `RXC_MCLK_DIV - 1) begin
               div_cnt_reg <= {`RXC_MCLK_CNT_W{1'b0}};
               div_tick_reg <= 1'b1;
            end else begin
               div_cnt_reg <= div_cnt_reg + 1'b1;
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : rx
         reg ext_prev_reg;
         reg mclk_tick_reg;
         reg rclk_prev_reg;
         reg rclk_pin_reg;
         reg [`RXC_SLOT_COUNT-1:0] slot_reg;
         reg mp_pin_reg;
         reg sd_reg;
         wire ds1e1 = ~mode[2*g+`RXC_MODE_NON_DS1E1_BIT];
         wire upd_edge = edge_seen(rclk_prev_reg, rclk_in[g], rc_inv[g]);
         wire fifo_valid;
         wire fifo_data;

         rx_bit_fifo #(
            .WIDTH(`RXC_FIFO_WIDTH),
            .DEPTH(`RXC_FIFO_DEPTH),
            .AW(`RXC_FIFO_AW)
         ) bit_fifo (
            .core_clk(core_clk),
            .resetn(resetn),
            .in_valid(bit_valid[g]),
            .in_ready(bit_ready[g]),
            .in_data(bit_data[g]),
            .out_valid(fifo_valid),
            .out_ready(upd_edge),
            .out_data(fifo_data)
         );

         always @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               ext_prev_reg <= 1'b0;
               mclk_tick_reg <= 1'b0;
               rclk_prev_reg <= 1'b0;
               rclk_pin_reg <= 1'b0;
               slot_reg <= {`RXC_SLOT_COUNT{1'b0}};
               mp_pin_reg <= 1'b0;
               sd_reg <= 1'b0;
            end else begin
               ext_prev_reg <= ext_pin[g];
               // pin edges only count when selected
               if (src_sel[g]) begin
                  mclk_tick_reg <= edge_seen(ext_prev_reg, ext_pin[g], 1'b0);
               end else begin
                  mclk_tick_reg <= div_tick_reg;
               end
               rclk_prev_reg <= rclk_in[g];
               rclk_pin_reg <= rc_en[g] ? rclk_in[g] : rc_inv[g];
               slot_reg <= slot_decode(dest[4*g+3 -: 4], rclk_in[g]);
               if (!mp_en[g]) begin
                  mp_pin_reg <= mp_inv[g];
               end else if (mp_sel[g] == `RXC_MPO_SRC_MULTIFRAME) begin
                  mp_pin_reg <= mfsync[g];
               end else begin
                  mp_pin_reg <= fsync[g];
               end
               // fifo drains on every chosen edge so no stale bits linger
               if (!ds1e1 || !sd_en[g]) begin
                  sd_reg <= 1'b0;
               end else if (upd_edge && fifo_valid) begin
                  sd_reg <= fifo_data;
               end
            end
         end

         assign mclk_tick[g] = mclk_tick_reg;
         assign rclk_pin[g] = rclk_pin_reg;
         assign slot[14*g+13 -: 14] = slot_reg;
         assign mp_pin[g] = mp_pin_reg;
         assign sd_pin[g] = sd_reg;
      end
   endgenerate

   assign xcvr_master_clock_tick_a = mclk_tick[0];
   assign xcvr_master_clock_tick_b = mclk_tick[1];
   assign rx_bit_ready_a = bit_ready[0];
   assign rx_bit_ready_b = bit_ready[1];
   assign recovered_clock_out_a = rclk_pin[0];
   assign recovered_clock_out_b = rclk_pin[1];
   assign recovered_clock_slot_a = slot[13:0];
   assign recovered_clock_slot_b = slot[27:14];
   assign rx_multipurpose_out_a = mp_pin[0];
   assign rx_multipurpose_out_b = mp_pin[1];
   assign rx_serial_data_out_a = sd_pin[0];
   assign rx_serial_data_out_b = sd_pin[1];
   // line input buffers released while powered down
   assign rx_line_input_en_a = ~pd[0];
   assign rx_line_input_en_b = ~pd[1];
endmodule

// [sim/framer_model.sv]
`timescale 1ns/100ps
module framer_model (
   input logic core_clk,
   input logic rclk,
   input logic inv,
   input logic ser
);
   logic last = 1'h0;
   logic got[$];
   // samples mid-bit, on the edge opposite the one that moves the data
   always @(posedge core_clk) begin
      last <= rclk;
      if (rclk != last && rclk == inv) got.push_back(ser);
   end
endmodule

// [sim/rx_mux_assertions.sv]
`timescale 1ns/100ps
module rx_mux_assertions (
   input logic core_clk,
   input logic resetn,
   input logic master_clock_source_sel_a,
   input logic ext_master_clock_pin_a,
   input logic xcvr_master_clock_tick_a,
   input logic rx_recovered_clock_a,
   input logic recovered_clock_out_en_a,
   input logic recovered_clock_invert_a,
   input logic recovered_clock_out_a,
   input logic [3:0] recovered_clock_dest_sel_a,
   input logic [13:0] recovered_clock_slot_a,
   input logic rx_multipurpose_out_en_a,
   input logic rx_multipurpose_source_sel_a,
   input logic rx_multipurpose_invert_a,
   input logic rx_frame_sync_a,
   input logic rx_multiframe_sync_a,
   input logic rx_multipurpose_out_a,
   input logic rx_power_down_a,
   input logic rx_line_input_en_a,
   input logic [1:0] rx_line_mode_a,
   input logic rx_serial_data_en_a,
   input logic rx_serial_data_out_a
);
   logic [1:0] rc_h;
   logic [3:0] pin_h;
   wire clk_exp = recovered_clock_out_en_a ? rx_recovered_clock_a : recovered_clock_invert_a;
   wire mpo_src = rx_multipurpose_source_sel_a ? rx_multiframe_sync_a : rx_frame_sync_a;
   wire mpo_exp = rx_multipurpose_out_en_a ? mpo_src : rx_multipurpose_invert_a;
   wire slot_hit = recovered_clock_dest_sel_a inside {[4'h1:4'hE]} && rx_recovered_clock_a;
   wire [13:0] slot_exp = slot_hit ? 14'h0001 << (recovered_clock_dest_sel_a - 4'h1) : 14'h0000;
   // history starts cleared, so a line held low looks quiet and stable right after a reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rc_h <= 2'h0;
         pin_h <= 4'h0;
      end else begin
         rc_h <= {rc_h[0], rx_recovered_clock_a};
         pin_h <= {pin_h[2:0], ext_master_clock_pin_a};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_clk_pin_mux: assert property (
      1 |=> recovered_clock_out_a == $past(clk_exp)) else $error("clock pin wrong");
   a_slot_forward: assert property (
      1 |=> recovered_clock_slot_a == $past(slot_exp)) else $error("slot wrong");
   a_mpo_mux: assert property (
      1 |=> rx_multipurpose_out_a == $past(mpo_exp)) else $error("sync pin wrong");
   a_line_hiz: assert property (
      rx_line_input_en_a == !rx_power_down_a) else $error("line input enable wrong");
   a_ser_low: assert property (
      rx_line_mode_a[1] || !rx_serial_data_en_a |=> !rx_serial_data_out_a)
      else $error("serial data not low");
   a_ser_hold: assert property (
      rc_h == {2{rx_recovered_clock_a}} && $stable(rx_serial_data_en_a)
      && $stable(rx_line_mode_a) |=> $stable(rx_serial_data_out_a))
      else $error("serial data moved without clock edge");
   a_ext_clk_used: assert property (
      master_clock_source_sel_a && $rose(ext_master_clock_pin_a)
      |-> ##[1:3] xcvr_master_clock_tick_a) else $error("external clock edge lost");
   a_div_ignored: assert property (
      master_clock_source_sel_a && $past(master_clock_source_sel_a, 3)
      && pin_h == {4{ext_master_clock_pin_a}} |=> !xcvr_master_clock_tick_a)
      else $error("tick without external edge");
   c_ext_edge: cover property (master_clock_source_sel_a && $rose(ext_master_clock_pin_a));
   c_ser_move: cover property (rx_serial_data_en_a && $rose(rx_serial_data_out_a));
   c_pd: cover property (rx_power_down_a && recovered_clock_dest_sel_a == 4'hE);
endmodule
bind timing_rx_clock_output_mux rx_mux_assertions chk_u (.*);

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   logic core_clk, resetn, master_clock_tick, ext_master_clock_pin_a, ext_master_clock_pin_b;
   logic master_clock_source_sel_a, master_clock_source_sel_b, rx_recovered_clock_a;
   logic rx_recovered_clock_b, rx_bit_data_a, rx_bit_data_b, rx_bit_valid_a, rx_bit_valid_b;
   logic rx_frame_sync_a, rx_frame_sync_b, rx_multiframe_sync_a, rx_multiframe_sync_b;
   logic [1:0] rx_line_mode_a, rx_line_mode_b;
   logic recovered_clock_out_en_a, recovered_clock_out_en_b, recovered_clock_invert_a;
   logic recovered_clock_invert_b, rx_multipurpose_out_en_a, rx_multipurpose_out_en_b;
   logic [3:0] recovered_clock_dest_sel_a, recovered_clock_dest_sel_b;
   logic rx_multipurpose_source_sel_a, rx_multipurpose_source_sel_b, rx_multipurpose_invert_a;
   logic rx_multipurpose_invert_b, rx_serial_data_en_a, rx_serial_data_en_b;
   logic rx_power_down_a, rx_power_down_b, xcvr_master_clock_tick_a, xcvr_master_clock_tick_b;
   logic rx_bit_ready_a, rx_bit_ready_b, recovered_clock_out_a, recovered_clock_out_b;
   logic [13:0] recovered_clock_slot_a, recovered_clock_slot_b;
   logic rx_multipurpose_out_a, rx_multipurpose_out_b, rx_serial_data_out_a;
   logic rx_serial_data_out_b, rx_line_input_en_a, rx_line_input_en_b;
   int num_errors = 0, n_tests = 0, ca = 0, cb = 0, rises = 0;
   logic gen_on = 1'h0;
   logic exp_q[$];
   timing_rx_clock_output_mux dut_u (.*);
   framer_model fm (.core_clk, .rclk(recovered_clock_out_a), .inv(recovered_clock_invert_a),
      .ser(rx_serial_data_out_a));
   task chk(input string nm, input logic [13:0] e, input logic [13:0] g);
      n_tests++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   function logic [13:0] f_slot(input logic [3:0] s, input logic r);
      return (s >= 4'h1 && s <= 4'hE && r) ? 14'h0001 << (s - 4'h1) : 14'h0000;
   endfunction
   task rnd_ctl;
      {rx_recovered_clock_a, recovered_clock_out_en_a, recovered_clock_invert_a,
         recovered_clock_dest_sel_a, rx_multipurpose_out_en_a, rx_multipurpose_source_sel_a,
         rx_multipurpose_invert_a, rx_frame_sync_a, rx_multiframe_sync_a, rx_power_down_a,
         rx_line_mode_a, rx_serial_data_en_a} <= $urandom;
      {rx_recovered_clock_b, recovered_clock_out_en_b, recovered_clock_invert_b,
         recovered_clock_dest_sel_b, rx_multipurpose_out_en_b, rx_multipurpose_source_sel_b,
         rx_multipurpose_invert_b, rx_frame_sync_b, rx_multiframe_sync_b, rx_power_down_b,
         rx_line_mode_b, rx_serial_data_en_b} <= $urandom;
   endtask
   task results;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      core_clk = 1'h0;
      forever #2 core_clk = !core_clk;
   end
   // about 16.384 MHz; despite the 1 ns start offset, the toggles at 62 ns and every 244 ns after land on a rising clock edge
   initial begin
      #1;
      forever #30.5 if (gen_on) begin
         ext_master_clock_pin_a = !ext_master_clock_pin_a;
         rises += ext_master_clock_pin_a;
      end
   end
   always @(posedge core_clk) begin
      ca += xcvr_master_clock_tick_a;
      cb += xcvr_master_clock_tick_b;
   end
   initial begin
      #50000;
      num_errors++;
      results();
   end
   initial begin
      void'($urandom(40));
      {resetn, master_clock_tick, ext_master_clock_pin_a, ext_master_clock_pin_b} = 4'h0;
      {rx_bit_data_a, rx_bit_data_b, rx_bit_valid_a, rx_bit_valid_b} = 4'h0;
      master_clock_source_sel_a = 1'h1;
      master_clock_source_sel_b = 1'h0;
      rnd_ctl();
      repeat (6) @(posedge core_clk);
      resetn <= 1'h1;
      @(posedge core_clk);
      #1 chk("ready_a", 14'h0001, rx_bit_ready_a);
      gen_on = 1'h1;
      for (int i = 0; i < 400; i++) begin
         @(posedge core_clk);
         master_clock_tick <= 1'h1;
         ext_master_clock_pin_b <= $urandom;
      end
      @(posedge core_clk);
      master_clock_tick <= 1'h0;
      gen_on = 1'h0;
      repeat (10) @(posedge core_clk);
      chk("tick_b", 14'h0004, cb[13:0]);
      chk("tick_a", rises[13:0], ca[13:0]);
      for (int i = 0; i < 200; i++) begin
         @(posedge core_clk);
         rnd_ctl();
         @(posedge core_clk);
         #1;
         chk("clk_a", recovered_clock_out_en_a ? rx_recovered_clock_a : recovered_clock_invert_a,
            recovered_clock_out_a);
         chk("clk_b", recovered_clock_out_en_b ? rx_recovered_clock_b : recovered_clock_invert_b,
            recovered_clock_out_b);
         chk("slot_a", f_slot(recovered_clock_dest_sel_a, rx_recovered_clock_a),
            recovered_clock_slot_a);
         chk("mpo_a", !rx_multipurpose_out_en_a ? rx_multipurpose_invert_a :
            rx_multipurpose_source_sel_a ? rx_multiframe_sync_a : rx_frame_sync_a,
            rx_multipurpose_out_a);
         chk("line_b", !rx_power_down_b, rx_line_input_en_b);
         chk("line_a", !rx_power_down_a, rx_line_input_en_a);
         chk("slot_b", f_slot(recovered_clock_dest_sel_b, rx_recovered_clock_b),
            recovered_clock_slot_b);
         chk("mpo_b", !rx_multipurpose_out_en_b ? rx_multipurpose_invert_b :
            rx_multipurpose_source_sel_b ? rx_multiframe_sync_b : rx_frame_sync_b,
            rx_multipurpose_out_b);
         chk("ser_b", 14'h0000, rx_serial_data_out_b);
         chk("ready_b", 14'h0001, rx_bit_ready_b);
      end
      for (int c = 0; c < 4; c++) begin
         @(posedge core_clk);
         {recovered_clock_out_en_a, recovered_clock_invert_a, rx_recovered_clock_a} <= {1'h1,
            c == 1, c == 1};
         rx_line_mode_a <= (c == 2) ? 2'h2 : 2'h0;
         rx_serial_data_en_a <= c != 3;
         repeat (4) @(posedge core_clk);
         fm.got.delete();
         for (int i = 0; i < 4; i++) begin
            rx_bit_valid_a <= 1'h1;
            rx_bit_data_a <= $urandom;
            @(posedge core_clk);
            exp_q.push_back(c < 2 && rx_bit_data_a);
         end
         rx_bit_valid_a <= 1'h0;
         #1 chk("full_a", 14'h0000, rx_bit_ready_a);
         repeat (8) begin
            repeat (4) @(posedge core_clk);
            rx_recovered_clock_a <= !rx_recovered_clock_a;
         end
         repeat (8) @(posedge core_clk);
         chk("nbits", 14'h0004, 14'(fm.got.size()));
         foreach (exp_q[i]) chk("bit", exp_q[i], fm.got[i]);
         exp_q.delete();
      end
      results();
   end
endmodule
